// file: rtl/eri_pkg.sv
/*
  Shared constants for the external request intake link: command field layout,
  command encodings, address field positions and the outstanding request limit.
  Assumes both ends and the bench compile this package first.
*/
package eri_pkg;
  localparam int CMD_W = 12;
  localparam int AD_W = 64;
  localparam int RESP_W = 5;
  localparam int RNUM_W = 3;
  localparam int NUM_RNUM = 8;
  localparam int MAX_OUTSTANDING = 8;
  localparam int CMD_EXT_BIT = 11;
  localparam int CMD_RNUM_HI = 10;
  localparam int CMD_RNUM_LO = 8;
  localparam int CMD_OP_HI = 7;
  localparam int CMD_OP_LO = 5;
  localparam int CMD_ECC_BIT = 0;
  localparam int AD_TGT_HI = 63;
  localparam int AD_TGT_LO = 60;
  localparam int AD_ADDR_HI = 39;
  localparam int AD_ADDR_LO = 0;
  localparam int RESP_RNUM_HI = 4;
  localparam int RESP_RNUM_LO = 2;
  localparam int RESP_KIND_HI = 1;
  localparam int RESP_KIND_LO = 0;
  localparam logic [2:0] OP_INTERVENE = 3'h0;
  localparam logic [2:0] OP_ALLOCATE = 3'h1;
  localparam logic [2:0] OP_INVALIDATE = 3'h2;
  localparam logic [1:0] RESP_ACK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h1;
  localparam logic [1:0] RESP_NACK = 2'h2;
endpackage

// file: rtl/eri_link_if.sv
/*
  Interface joining the processor end and the external agent end.
  Assumes a single core_clk domain; all strobes are active low.
*/
`timescale 1ns/100ps
interface eri_link_if;
  logic bus_grant_n;
  logic bus_release_n;
  logic bus_valid_n;
  logic [eri_pkg::CMD_W-1:0] command_bus;
  logic [eri_pkg::AD_W-1:0] addr_data_bus;
  logic resp_valid_n;
  logic [eri_pkg::RESP_W-1:0] completion_response_bus;
  modport device (
    input bus_grant_n,
    output bus_release_n,
    input bus_valid_n,
    input command_bus,
    input addr_data_bus,
    input resp_valid_n,
    input completion_response_bus
  );
  modport agent (
    output bus_grant_n,
    input bus_release_n,
    output bus_valid_n,
    output command_bus,
    output addr_data_bus,
    output resp_valid_n,
    output completion_response_bus
  );
endinterface

// file: rtl/eri_device.sv
/*
  Processor end of the external request intake: gives up mastership on grant
  negation, captures external request address cycles, tracks request numbers.
  Assumes the agent end on the same core_clk, joined through eri_link_if.
*/
`timescale 1ns/100ps
// Contract
// - Agent requests only in slave state.
// - Grant negated, release asserted, then slave.
// - Already slave: agent requests immediately; eri_agent still waits in ERIA_WAIT for a release pulse.
// - At most eight external requests outstanding.
// - Device accepts requests back to back.
// - Intervene and invalidate are coherency requests.
// - Device services intervention for shared/exclusive copy.
// - Intervention is one valid address cycle.
// - Bit 11 low, request number bits 10:8.
// - Command encoding on bits 7:5.
// - ECC check indication on bit 0.
// - Target indication on bits 63:60.
// - Physical block address on bits 39:0.
// - Agent normally picks a free request number.
// - At most eight interventions outstanding.
// - Completion carries request number on 4:2.
// - ERR/NACK completion only frees number.
module eri_device (
  input wire logic core_clk,
  input wire logic reset_n,
  eri_link_if.device link,
  input wire logic master_want,
  output logic slave_state,
  output logic req_valid,
  output logic req_coherency,
  output logic req_intervene,
  output logic [2:0] req_op,
  output logic [eri_pkg::RNUM_W-1:0] req_rnum,
  output logic req_ecc_check,
  output logic [3:0] req_target,
  output logic [eri_pkg::AD_ADDR_HI:0] req_addr,
  output logic [eri_pkg::NUM_RNUM-1:0] rnum_busy,
  output logic protocol_error
);
  // ----------------------------------------------------------------
  // Mastership
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ERI_MASTER, ERI_RELEASE, ERI_SLAVE} eri_mst_t;
  eri_mst_t mst_q, mst_d;
  wire grant_neg = link.bus_grant_n;
  wire grant_back = !link.bus_grant_n && master_want;
  always_comb begin
    mst_d = mst_q;
    unique case (mst_q)
      ERI_MASTER: if (grant_neg) mst_d = ERI_RELEASE;
      ERI_RELEASE: mst_d = ERI_SLAVE;
      ERI_SLAVE: if (grant_back) mst_d = ERI_MASTER;
      // The unused code falls back to master, the state the bus starts in.
      default: mst_d = ERI_MASTER;
    endcase
  end
  logic rel_n_q;
  logic rel_n_d;
  // The release pulse is one cycle wide, since the state passes through release once.
  assign rel_n_d = !(mst_d == ERI_RELEASE);
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mst_q <= ERI_MASTER;
    end else begin
      mst_q <= mst_d;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rel_n_q <= 1'b1;
    end else begin
      rel_n_q <= rel_n_d;
    end
  end
  assign link.bus_release_n = rel_n_q;
  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  // Taken in every slave cycle with valid low and bit 11 low, so adjacent cycles both land.
  wire in_slave = (mst_q == ERI_SLAVE);
  wire [eri_pkg::CMD_W-1:0] cmd = link.command_bus;
  wire take = in_slave && !link.bus_valid_n && !cmd[eri_pkg::CMD_EXT_BIT];
  wire stray = !in_slave && !link.bus_valid_n;
  wire [2:0] op = cmd[eri_pkg::CMD_OP_HI:eri_pkg::CMD_OP_LO];
  wire [eri_pkg::RNUM_W-1:0] rnum = cmd[eri_pkg::CMD_RNUM_HI:eri_pkg::CMD_RNUM_LO];
  wire is_ivn = (op == eri_pkg::OP_INTERVENE);
  wire is_coh = is_ivn || (op == eri_pkg::OP_INVALIDATE);
  wire resp_take = !link.resp_valid_n;
  wire [eri_pkg::RNUM_W-1:0] resp_rnum =
    link.completion_response_bus[eri_pkg::RESP_RNUM_HI:eri_pkg::RESP_RNUM_LO];
  // ----------------------------------------------------------------
  // Request number tracking
  // ----------------------------------------------------------------
  // Any completion kind, including ERR or NACK, only frees the number; set wins.
  logic [eri_pkg::NUM_RNUM-1:0] busy_q;
  logic [eri_pkg::NUM_RNUM-1:0] busy_d;
  logic [eri_pkg::NUM_RNUM-1:0] set_hit;
  logic [eri_pkg::NUM_RNUM-1:0] clr_hit;
  genvar g;
  generate
    for (g = 0; g < eri_pkg::NUM_RNUM; g++) begin : g_rn
      assign set_hit[g] = take && (rnum == g);
      assign clr_hit[g] = resp_take && (resp_rnum == g);
      assign busy_d[g] = set_hit[g] || (busy_q[g] && !clr_hit[g]);
    end
  endgenerate
  // A number freed in the very cycle it is reused is not counted as a reuse.
  wire reuse = take && busy_q[rnum] && !clr_hit[rnum];
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      busy_q <= '0;
    end else begin
      busy_q <= busy_d;
    end
  end
  // ----------------------------------------------------------------
  // Request strobes
  // ----------------------------------------------------------------
  wire coh_d = take && is_coh;
  wire ivn_d = take && is_ivn;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      req_valid <= 1'b0;
      req_coherency <= 1'b0;
      req_intervene <= 1'b0;
    end else begin
      req_valid <= take;
      req_coherency <= coh_d;
      req_intervene <= ivn_d;
    end
  end
  // ----------------------------------------------------------------
  // Captured fields
  // ----------------------------------------------------------------
  // Fields hold the last capture, so a consumer must qualify them with req_valid.
  wire ecc_bit = cmd[eri_pkg::CMD_ECC_BIT];
  wire [3:0] tgt_field = link.addr_data_bus[eri_pkg::AD_TGT_HI:eri_pkg::AD_TGT_LO];
  wire [eri_pkg::AD_ADDR_HI:0] addr_field =
    link.addr_data_bus[eri_pkg::AD_ADDR_HI:eri_pkg::AD_ADDR_LO];
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      req_op <= 3'h0;
      req_rnum <= '0;
      req_ecc_check <= 1'b0;
      req_target <= 4'h0;
      req_addr <= '0;
    end else if (take) begin
      req_op <= op;
      req_rnum <= rnum;
      req_ecc_check <= ecc_bit;
      req_target <= tgt_field;
      req_addr <= addr_field;
    end
  end
  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  wire slave_d = (mst_d == ERI_SLAVE);
  wire perr_d = stray || reuse;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      slave_state <= 1'b0;
      protocol_error <= 1'b0;
    end else begin
      slave_state <= slave_d;
      protocol_error <= perr_d;
    end
  end
  assign rnum_busy = busy_q;
endmodule

// file: rtl/eri_agent.sv
/*
  External agent end: wins slave state by negating grant, issues single
  address cycle requests, limits outstanding requests and sends completions.
  Assumes the processor end on the same core_clk through eri_link_if.
*/
`timescale 1ns/100ps
module eri_agent (
  input wire logic core_clk,
  input wire logic reset_n,
  eri_link_if.agent link,
  input wire logic issue_req,
  input wire logic [2:0] issue_op,
  input wire logic issue_ecc,
  input wire logic [3:0] issue_target,
  input wire logic [eri_pkg::AD_ADDR_HI:0] issue_addr,
  input wire logic give_back,
  input wire logic complete_req,
  input wire logic [eri_pkg::RNUM_W-1:0] complete_rnum,
  input wire logic [1:0] complete_kind,
  output logic issue_ready,
  output logic [eri_pkg::RNUM_W-1:0] issued_rnum,
  output logic [eri_pkg::NUM_RNUM-1:0] outstanding
);
  // ----------------------------------------------------------------
  // Slave state tracking
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ERIA_IDLE, ERIA_WAIT, ERIA_SLAVE} eria_st_t;
  eria_st_t st_q, st_d;
  wire released = !link.bus_release_n;
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ERIA_IDLE: st_d = ERIA_WAIT;
      ERIA_WAIT: if (released) st_d = ERIA_SLAVE;
      ERIA_SLAVE: if (give_back) st_d = ERIA_IDLE;
    endcase
  end
  // ----------------------------------------------------------------
  // Request numbers
  // ----------------------------------------------------------------
  logic [eri_pkg::NUM_RNUM-1:0] out_q;
  logic [eri_pkg::NUM_RNUM-1:0] out_d;
  logic [eri_pkg::RNUM_W-1:0] free_rn;
  logic any_free;
  always_comb begin
    free_rn = '0;
    any_free = 1'b0;
    for (int i = eri_pkg::NUM_RNUM - 1; i >= 0; i--) begin
      if (!out_q[i]) begin
        free_rn = i[eri_pkg::RNUM_W-1:0];
        any_free = 1'b1;
      end
    end
  end
  // Eight numbers bound the outstanding count at eight in total, of all kinds together.
  wire can_issue = (st_q == ERIA_SLAVE) && any_free && !give_back;
  wire fire = issue_req && can_issue;
  wire done = complete_req && out_q[complete_rnum];
  genvar g;
  generate
    for (g = 0; g < eri_pkg::NUM_RNUM; g++) begin : g_out
      assign out_d[g] = (fire && free_rn == g) || (out_q[g] && !(done && complete_rnum == g));
    end
  endgenerate
  wire [eri_pkg::CMD_W-1:0] cmd_word = {1'b0, free_rn, issue_op, 4'h0, issue_ecc};
  wire [eri_pkg::AD_W-1:0] ad_word = {issue_target, 20'h00000, issue_addr};
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q <= ERIA_IDLE;
      out_q <= '0;
      link.bus_grant_n <= 1'b0;
      link.bus_valid_n <= 1'b1;
      link.command_bus <= '0;
      link.addr_data_bus <= '0;
      link.resp_valid_n <= 1'b1;
      link.completion_response_bus <= '0;
      issue_ready <= 1'b0;
      issued_rnum <= '0;
    end else begin
      st_q <= st_d;
      out_q <= out_d;
      link.bus_grant_n <= (st_d != ERIA_IDLE);
      link.bus_valid_n <= !fire;
      link.command_bus <= fire ? cmd_word : '0;
      link.addr_data_bus <= fire ? ad_word : '0;
      link.resp_valid_n <= !done;
      link.completion_response_bus <= {complete_rnum, complete_kind};
      issue_ready <= (st_d == ERIA_SLAVE) && !(&out_d);
      if (fire) issued_rnum <= free_rn;
    end
  end
  assign outstanding = out_q;
endmodule

// file: dv/eri_props.sv
/* Checker for the wires of eri_link_if.
   Assumes one core_clk domain and strobes active low. */
`timescale 1ns/100ps
module eri_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic bus_grant_n,
  input wire logic bus_release_n,
  input wire logic bus_valid_n,
  input wire logic [11:0] command_bus,
  input wire logic [63:0] addr_data_bus,
  input wire logic resp_valid_n,
  input wire logic [4:0] completion_response_bus
);
  // ----------------------------------------
  // Shadow state
  // ----------------------------------------
  logic slave_q;
  logic [7:0] busy_q;
  logic [3:0] cnt_q;
  wire [2:0] resp_rnum = completion_response_bus[4:2];
  wire [2:0] cmd_rnum = command_bus[10:8];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Set wins over clear, as in the device, but a reuse in the cycle its completion arrives is still flagged.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      slave_q <= 1'b0;
      busy_q <= 8'h00;
      cnt_q <= 4'h0;
    end else begin
      slave_q <= (slave_q | !bus_release_n) & bus_grant_n;
      busy_q <= (busy_q & ~(8'(!resp_valid_n) << resp_rnum)) | (8'(!bus_valid_n) << cmd_rnum);
      cnt_q <= cnt_q + 4'(!bus_valid_n) - 4'(!resp_valid_n);
    end
  end
  valid_when_slave_a: assert property (!bus_valid_n |-> slave_q)
    else $error("valid outside slave state");
  release_pulse_a: assert property (!bus_release_n |=> bus_release_n)
    else $error("release held longer than one cycle");
  grant_release_a: assert property ($rose(bus_grant_n) |-> ##[1:4] !bus_release_n)
    else $error("no release after grant negation");
  ext_bit_low_a: assert property (!bus_valid_n |-> !command_bus[11])
    else $error("external bit high in address cycle");
  op_legal_a: assert property (!bus_valid_n |-> command_bus[7:5] <= 3'h2)
    else $error("unknown command encoding");
  limit_eight_a: assert property (cnt_q <= 4'h8)
    else $error("more than eight outstanding");
  resp_busy_a: assert property (!resp_valid_n |-> busy_q[resp_rnum])
    else $error("completion for idle number");
  fresh_rnum_a: assert property (!bus_valid_n |-> !busy_q[cmd_rnum])
    else $error("busy number reused");
  back_to_back_c: cover property (!bus_valid_n ##1 !bus_valid_n);
  completion_c: cover property (!resp_valid_n);
  release_c: cover property (!bus_release_n);
  regain_c: cover property ($rose(bus_grant_n) ##[1:4] !bus_release_n);
endmodule

// file: dv/test_external_request_intake.sv
/* Bench for eri_device facing eri_agent across eri_link_if.
   Assumes the rtl package, interface and both ends compile first. */
`timescale 1ns/100ps
module test_external_request_intake;
  // ----------------------------------------
  // Stimulus, instances and monitor
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic issue_req = 1'b0;
  logic [2:0] issue_op = 3'h0;
  logic issue_ecc = 1'b0;
  logic [3:0] issue_target = 4'h0;
  logic [39:0] issue_addr = 40'h0;
  logic complete_req = 1'b0;
  logic master_want = 1'b0;
  logic give_back = 1'b0;
  logic [2:0] complete_rnum = 3'h0;
  logic [1:0] complete_kind = 2'h0;
  logic slave_state, req_valid, req_coherency, req_intervene, req_ecc_check, protocol_error;
  logic [2:0] req_op, req_rnum;
  logic [3:0] req_target;
  logic [39:0] req_addr;
  logic [7:0] rnum_busy, outstanding;
  logic issue_ready;
  logic [2:0] issued_rnum;
  logic prev_v = 1'b0;
  logic b2b = 1'b0;
  logic rel_seen = 1'b0;
  logic perr_seen = 1'b0;
  logic [11:0] cmd_seen;
  logic [63:0] ad_seen;
  int n_valid = 0;
  int n_fail = 0;
  int num_checks = 0;
  eri_link_if link ();
  eri_device eri_device_inst (.core_clk, .reset_n, .link(link), .master_want,
    .slave_state, .req_valid, .req_coherency, .req_intervene, .req_op, .req_rnum,
    .req_ecc_check, .req_target, .req_addr, .rnum_busy, .protocol_error);
  eri_agent eri_agent_inst (.core_clk, .reset_n, .link(link), .issue_req, .issue_op,
    .issue_ecc, .issue_target, .issue_addr, .give_back, .complete_req,
    .complete_rnum, .complete_kind, .issue_ready, .issued_rnum, .outstanding);
  eri_props eri_props_inst (.core_clk, .reset_n, .bus_grant_n(link.bus_grant_n),
    .bus_release_n(link.bus_release_n), .bus_valid_n(link.bus_valid_n),
    .command_bus(link.command_bus), .addr_data_bus(link.addr_data_bus),
    .resp_valid_n(link.resp_valid_n), .completion_response_bus(link.completion_response_bus));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    prev_v <= !link.bus_valid_n;
    rel_seen <= rel_seen | !link.bus_release_n;
    perr_seen <= perr_seen | (protocol_error === 1'b1);
    if (!link.bus_valid_n) begin
      n_valid <= n_valid + 1;
      b2b <= b2b | prev_v;
      cmd_seen <= link.command_bus;
      ad_seen <= link.addr_data_bus;
    end
  end
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic s_handshake();
    for (int i = 0; i < 20 && slave_state !== 1'b1; i++) begin
      tick(1);
    end
    check("slave", 1'b1, slave_state);
    check("release", 1'b1, rel_seen);
    tick(1);
  endtask
  task automatic s_one(input logic [2:0] op, input logic [2:0] rn, input logic coh);
    issue_op = op;
    issue_ecc = rn[0];
    issue_target = {1'b1, rn};
    issue_addr = 40'hab_cdef_0123 ^ {37'h0, rn};
    issue_req = 1'b1;
    tick(1);
    issue_req = 1'b0;
    for (int i = 0; i < 20 && req_valid !== 1'b1; i++) begin
      tick(1);
    end
    if (req_valid !== 1'b1) begin
      n_fail++;
      conclude();
    end
    check("op", op, req_op);
    check("rnum", rn, req_rnum);
    check("coherency", coh, req_coherency);
    check("intervene", op == eri_pkg::OP_INTERVENE, req_intervene);
    check("ecc", rn[0], req_ecc_check);
    check("target", issue_target, req_target);
    check("addr", issue_addr, req_addr);
    check("cmd", {1'b0, rn, op, rn[0]}, {cmd_seen[11:5], cmd_seen[0]});
    check("ad", {issue_target, issue_addr}, {ad_seen[63:60], ad_seen[39:0]});
    check("busy", 1'b1, rnum_busy[rn]);
    check("issued", rn, issued_rnum);
    check("ready", 1'b1, issue_ready);
  endtask
  task automatic s_fill();
    int base;
    base = n_valid;
    issue_op = eri_pkg::OP_INTERVENE;
    issue_req = 1'b1;
    tick(7);
    issue_req = 1'b0;
    tick(3);
    check("count", base + 5, n_valid);
    check("b2b", 1'b1, b2b);
    check("busy", 8'hff, rnum_busy);
    check("agent", 8'hff, outstanding);
    check("ready", 1'b0, issue_ready);
  endtask
  task automatic s_regain();
    master_want = 1'b1;
    give_back = 1'b1;
    tick(1);
    give_back = 1'b0;
    for (int i = 0; i < 20 && slave_state !== 1'b0; i++) begin
      tick(1);
    end
    master_want = 1'b0;
    check("dropped", 1'b0, slave_state);
    for (int i = 0; i < 20 && slave_state !== 1'b1; i++) begin
      tick(1);
    end
    check("regained", 1'b1, slave_state);
    tick(1);
  endtask
  task automatic s_complete();
    for (int k = 0; k < 3; k++) begin
      complete_rnum = k[2:0];
      complete_kind = k[1:0];
      complete_req = 1'b1;
      tick(1);
      complete_req = 1'b0;
      tick(3);
      check("freed", 8'(8'hff << (k + 1)), rnum_busy);
    end
  endtask
  initial begin
    tick(12);
    reset_n = 1'b1;
    s_handshake();
    s_one(eri_pkg::OP_INTERVENE, 3'h0, 1'b1);
    s_one(eri_pkg::OP_ALLOCATE, 3'h1, 1'b0);
    s_one(eri_pkg::OP_INVALIDATE, 3'h2, 1'b1);
    s_fill();
    s_complete();
    s_regain();
    s_one(eri_pkg::OP_INTERVENE, 3'h0, 1'b1);
    check("perr", 1'b0, perr_seen);
    conclude();
  end
endmodule
